// [digital_input_pkg.sv]
// Shared constants and bus carriers for the digital input conditioning block.
// Assumes an AXI4-Lite master with 8-bit addresses and 32-bit data on the register side.
package digital_input_pkg;

   // ==========================================================================
   // Widths and counts
   // ==========================================================================
   localparam int ADDR_W = 8;            // Register bus address width in bits.
   localparam int NUM_IN = 8;            // Four low-group plus four high-group inputs.
   localparam int NUM_LOW = 4;           // Inputs that carry an inversion setting.
   localparam int FILTER_W = 16;         // Width of the input filter setting.
   localparam int ALARM_CNT_W = 3;       // Holds up to three steps of two cycles.
   localparam int ALARM_STEP_CYCLES = 2; // Control cycles per alarm filter step.
   localparam int STATUS_ALARM_BIT = 8;  // Alarm level position in the status word.

   // ==========================================================================
   // Register byte offsets
   // ==========================================================================
   localparam logic [ADDR_W-1:0] OFF_SEL_LOW = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_SEL_HIGH = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_FILTER = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_ALARM = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_INVERT = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_BUS_VALUE = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;

   // ==========================================================================
   // Reset values and limits
   // ==========================================================================
   localparam logic [3:0] SEL_LOW_RST = 4'h0;
   localparam logic [3:0] SEL_HIGH_RST = 4'h0;
   localparam logic [3:0] INVERT_RST = 4'h0;
   localparam logic [7:0] BUS_VALUE_RST = 8'h00;
   localparam logic [FILTER_W-1:0] FILTER_RST = 16'h0001;
   localparam logic [FILTER_W-1:0] FILTER_MAX = 16'h03E8;
   localparam logic [1:0] ALARM_RST = 2'h1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================================
   // AXI4-Lite carriers
   // ==========================================================================
   // Master to slave signals.
   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } axi_req_t;

   // Slave to master signals.
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axi_rsp_t;

endpackage : digital_input_pkg

// [digital_input_conditioning.sv]
// Digital input conditioning: source select and stability filters for eight drive inputs,
// inversion for the four low-group inputs, plus the alarm output filter, configured over AXI4-Lite.
// Assumes terminals are asynchronous pins and the alarm level comes from logic on sys_clk.
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module digital_input_conditioning #(
   parameter int CTRL_DIV = 1 // Clocks per control cycle; 1 makes every clock a control cycle.
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire digital_input_pkg::axi_req_t axiReq,
   output digital_input_pkg::axi_rsp_t axiRsp,
   input wire logic inputTerminalA,
   input wire logic inputTerminalB,
   input wire logic inputTerminalC,
   input wire logic inputTerminalD,
   input wire logic [3:0] inputTerminalHigh,
   input wire logic alarmIn,
   output logic [digital_input_pkg::NUM_IN-1:0] condIn,
   output logic alarmOut
);

   // ==========================================================================
   // Control cycle divider
   // ==========================================================================
   logic [15:0] divCnt; // Clocks elapsed in the current control cycle.
   logic tick; // One-cycle pulse marking a control cycle.
   logic [15:0] next_divCnt;
   logic next_tick;

   // Divides sys_clk down to the control cycle enable.
   always_comb begin
      next_divCnt = divCnt + 16'h0001;
      next_tick = 1'b0;
      if (divCnt >= 16'(CTRL_DIV - 1)) begin
         next_divCnt = 16'h0000;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         divCnt <= 16'h0000;
         tick <= 1'b0;
      end else begin
         divCnt <= next_divCnt;
         tick <= next_tick;
      end
   end

   // ==========================================================================
   // Register file and AXI4-Lite slave
   // ==========================================================================
   logic [3:0] selLow, selHigh, invert; // Source and inversion settings.
   logic [digital_input_pkg::FILTER_W-1:0] filterCycles; // Input filter length.
   logic [1:0] alarmCfg; // Alarm filter steps.
   logic [7:0] busValue; // Virtual input levels written by the bus master.
   logic awHeld, wHeld; // Address or data accepted and waiting for its partner.
   logic [digital_input_pkg::ADDR_W-1:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic awReady, wReady, bValid, arReady, rValid;
   logic [1:0] bResp, rResp;
   logic [31:0] rData;
   logic [3:0] next_selLow, next_selHigh, next_invert;
   logic [digital_input_pkg::FILTER_W-1:0] next_filterCycles;
   logic [1:0] next_alarmCfg;
   logic [7:0] next_busValue;
   logic next_awHeld, next_wHeld, next_awReady, next_wReady, next_bValid, next_arReady, next_rValid;
   logic [digital_input_pkg::ADDR_W-1:0] next_awAddr;
   logic [31:0] next_wData, next_rData;
   logic [3:0] next_wStrb;
   logic [1:0] next_bResp, next_rResp;

   // Merges a write into the old word lane by lane.
   function automatic logic [31:0] mergeWord(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = data[8*b +: 8];
         end
      end
      return res;
   endfunction : mergeWord

   // Handles both channels; one write and one read at a time, the write commits
   // once address and data are both held and the previous response is gone.
   always_comb begin
      logic [31:0] merged;
      merged = 32'h0000_0000;
      next_selLow = selLow;
      next_selHigh = selHigh;
      next_invert = invert;
      next_filterCycles = filterCycles;
      next_alarmCfg = alarmCfg;
      next_busValue = busValue;
      next_awHeld = awHeld;
      next_wHeld = wHeld;
      next_awAddr = awAddr;
      next_wData = wData;
      next_wStrb = wStrb;
      next_bValid = bValid;
      next_bResp = bResp;
      next_rValid = rValid;
      next_rData = rData;
      next_rResp = rResp;
      if (bValid && axiReq.bready) begin
         next_bValid = 1'b0;
      end
      if (axiReq.awvalid && awReady) begin
         next_awHeld = 1'b1;
         next_awAddr = axiReq.awaddr;
      end
      if (axiReq.wvalid && wReady) begin
         next_wHeld = 1'b1;
         next_wData = axiReq.wdata;
         next_wStrb = axiReq.wstrb;
      end
      if (awHeld && wHeld && !bValid) begin
         next_awHeld = 1'b0;
         next_wHeld = 1'b0;
         next_bValid = 1'b1;
         next_bResp = digital_input_pkg::RESP_OKAY;
         case (awAddr)
            digital_input_pkg::OFF_SEL_LOW: begin
               merged = mergeWord({28'h0, selLow}, wData, wStrb);
               next_selLow = merged[3:0];
            end
            digital_input_pkg::OFF_SEL_HIGH: begin
               merged = mergeWord({28'h0, selHigh}, wData, wStrb);
               next_selHigh = merged[3:0];
            end
            digital_input_pkg::OFF_FILTER: begin
               merged = mergeWord({16'h0, filterCycles}, wData, wStrb);
               // Values past the documented range are clamped rather than refused.
               next_filterCycles = (merged[15:0] > digital_input_pkg::FILTER_MAX) ?
                                   digital_input_pkg::FILTER_MAX : merged[15:0];
            end
            digital_input_pkg::OFF_ALARM: begin
               merged = mergeWord({30'h0, alarmCfg}, wData, wStrb);
               next_alarmCfg = merged[1:0];
            end
            digital_input_pkg::OFF_INVERT: begin
               merged = mergeWord({28'h0, invert}, wData, wStrb);
               next_invert = merged[3:0];
            end
            digital_input_pkg::OFF_BUS_VALUE: begin
               merged = mergeWord({24'h0, busValue}, wData, wStrb);
               next_busValue = merged[7:0];
            end
            default: begin
               // Status is read only; it and unmapped addresses answer with an error.
               next_bResp = digital_input_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (rValid && axiReq.rready) begin
         next_rValid = 1'b0;
      end
      if (axiReq.arvalid && arReady) begin
         next_rValid = 1'b1;
         next_rResp = digital_input_pkg::RESP_OKAY;
         case (axiReq.araddr)
            digital_input_pkg::OFF_SEL_LOW: next_rData = {28'h0, selLow};
            digital_input_pkg::OFF_SEL_HIGH: next_rData = {28'h0, selHigh};
            digital_input_pkg::OFF_FILTER: next_rData = {16'h0, filterCycles};
            digital_input_pkg::OFF_ALARM: next_rData = {30'h0, alarmCfg};
            digital_input_pkg::OFF_INVERT: next_rData = {28'h0, invert};
            digital_input_pkg::OFF_BUS_VALUE: next_rData = {24'h0, busValue};
            digital_input_pkg::OFF_STATUS: next_rData = {23'h0, alarmOut, condIn};
            default: begin
               next_rData = 32'h0000_0000;
               next_rResp = digital_input_pkg::RESP_SLVERR;
            end
         endcase
      end
      next_awReady = !next_awHeld;
      next_wReady = !next_wHeld;
      next_arReady = !next_rValid;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         selLow <= digital_input_pkg::SEL_LOW_RST;
         selHigh <= digital_input_pkg::SEL_HIGH_RST;
         invert <= digital_input_pkg::INVERT_RST;
         filterCycles <= digital_input_pkg::FILTER_RST;
         alarmCfg <= digital_input_pkg::ALARM_RST;
         busValue <= digital_input_pkg::BUS_VALUE_RST;
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 8'h00;
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
         awReady <= 1'b0;
         wReady <= 1'b0;
         bValid <= 1'b0;
         bResp <= 2'h0;
         arReady <= 1'b0;
         rValid <= 1'b0;
         rData <= 32'h0000_0000;
         rResp <= 2'h0;
      end else begin
         selLow <= next_selLow;
         selHigh <= next_selHigh;
         invert <= next_invert;
         filterCycles <= next_filterCycles;
         alarmCfg <= next_alarmCfg;
         busValue <= next_busValue;
         awHeld <= next_awHeld;
         wHeld <= next_wHeld;
         awAddr <= next_awAddr;
         wData <= next_wData;
         wStrb <= next_wStrb;
         awReady <= next_awReady;
         wReady <= next_wReady;
         bValid <= next_bValid;
         bResp <= next_bResp;
         arReady <= next_arReady;
         rValid <= next_rValid;
         rData <= next_rData;
         rResp <= next_rResp;
      end
   end

   // Every response field comes straight from a flip-flop.
   assign axiRsp = '{awready: awReady, wready: wReady, bvalid: bValid, bresp: bResp,
                     arready: arReady, rvalid: rValid, rdata: rData, rresp: rResp};

   // ==========================================================================
   // Per-input synchroniser, source select, inversion and filter
   // ==========================================================================
   logic [7:0] pins; // Raw terminal levels, low group first.
   logic [7:0] cand; // Level offered to each filter.
   logic [digital_input_pkg::FILTER_W-1:0] fCnt [digital_input_pkg::NUM_IN]; // Stable time.
   assign pins = {inputTerminalHigh, inputTerminalD, inputTerminalC, inputTerminalB, inputTerminalA};

   for (genvar i = 0; i < digital_input_pkg::NUM_IN; i++) begin : g_in
      logic s1, s2, s3, pinLvl; // s1 feeds only s2; pinLvl moves once s2 and s3 agree.
      logic next_pinLvl, next_cond, srcSel, invSel;
      logic [digital_input_pkg::FILTER_W-1:0] next_fCnt;

      // Picks the source and applies inversion; only the low group can be inverted.
      always_comb begin
         srcSel = (i < digital_input_pkg::NUM_LOW) ? selLow[i % 4] : selHigh[i % 4];
         invSel = (i < digital_input_pkg::NUM_LOW) ? invert[i % 4] : 1'b0;
         cand[i] = (srcSel ? busValue[i] : pinLvl) ^ invSel;
      end

      // A level must hold for filterCycles control cycles before it is taken; zero takes it at once.
      always_comb begin
         next_pinLvl = (s2 == s3) ? s3 : pinLvl;
         next_cond = condIn[i];
         next_fCnt = 16'h0000;
         if (cand[i] != condIn[i]) begin
            if (fCnt[i] >= filterCycles) begin
               next_cond = cand[i];
            end else begin
               next_fCnt = (tick && fCnt[i] != 16'hFFFF) ? fCnt[i] + 16'h0001 : fCnt[i];
            end
         end
      end

      always_ff @(posedge sys_clk or negedge rst_b) begin
         if (!rst_b) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            pinLvl <= 1'b0;
            condIn[i] <= 1'b0;
            fCnt[i] <= 16'h0000;
         end else begin
            s1 <= pins[i];
            s2 <= s1;
            s3 <= s2;
            pinLvl <= next_pinLvl;
            condIn[i] <= next_cond;
            fCnt[i] <= next_fCnt;
         end
      end
   end

   // ==========================================================================
   // Alarm output filter
   // ==========================================================================
   logic [digital_input_pkg::ALARM_CNT_W-1:0] alarmCnt, next_alarmCnt, alarmLimit;
   logic next_alarmOut;

   // The alarm level must hold for two control cycles per configured step.
   always_comb begin
      alarmLimit = 3'(alarmCfg * digital_input_pkg::ALARM_STEP_CYCLES);
      next_alarmOut = alarmOut;
      next_alarmCnt = 3'h0;
      if (alarmIn != alarmOut) begin
         if (alarmCnt >= alarmLimit) begin
            next_alarmOut = alarmIn;
         end else begin
            next_alarmCnt = tick ? alarmCnt + 3'h1 : alarmCnt;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         alarmCnt <= 3'h0;
         alarmOut <= 1'b0;
      end else begin
         alarmCnt <= next_alarmCnt;
         alarmOut <= next_alarmOut;
      end
   end

   // ==========================================================================
   // Assertions
   // ==========================================================================
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   bus_low_select_a: assert property (selLow[0] && !invert[0] && filterCycles == 16'h0000 |=>
      condIn[0] == $past(busValue[0])) else $error("Low input 0 ignores bus value.");
   bus_high_select_a: assert property (selHigh[0] && filterCycles == 16'h0000 |=>
      condIn[4] == $past(busValue[4])) else $error("High input 0 ignores bus value.");
   input_invert_a: assert property (selLow[1] && invert[1] && filterCycles == 16'h0000 |=>
      condIn[1] == !$past(busValue[1])) else $error("Inverted input not inverted.");
   filter_hold_a: assert property ($changed(condIn[0]) |->
      $past(fCnt[0]) >= $past(filterCycles)) else $error("Input changed before filter time.");
   filter_zero_a: assert property (filterCycles == 16'h0000 && cand[2] != condIn[2] |=>
      $changed(condIn[2])) else $error("Zero filter did not pass input.");
   alarm_filter_a: assert property ($changed(alarmOut) |->
      $past(alarmCnt) >= 3'($past(alarmCfg) * 2)) else $error("Alarm changed too early.");

   bus_write_c: cover property (bValid && axiReq.bready && bResp == digital_input_pkg::RESP_OKAY);
   input_rise_c: cover property ($rose(condIn[0]) && filterCycles > 16'h0001);
   alarm_change_c: cover property ($changed(alarmOut) && alarmCfg == 2'h3);

endmodule : digital_input_conditioning

`default_nettype wire

// [terminal_source_model.sv]
// Behavioural model of the switches and sensors on the input terminals and of the
// drive logic that raises the alarm level. Assumes the bench calls its tasks in order.
`timescale 1ns/1ns
`default_nettype none

module terminal_source_model (
   input wire logic sys_clk,
   output logic [3:0] termLow,
   output logic [3:0] termHigh,
   output logic alarmLvl
);
   // ==========================================================================
   // Terminal levels
   // ==========================================================================
   // All lines start low; a real switch has a defined level at power-up.
   initial begin
      termLow = 4'h0;
      termHigh = 4'h0;
      alarmLvl = 1'b0;
   end

   // Moves every terminal just after a rising edge and holds it there.
   task automatic drive(input logic [3:0] lo, input logic [3:0] hi);
      @(posedge sys_clk);
      termLow <= lo;
      termHigh <= hi;
   endtask : drive

   // A contact bounce: the low group takes a level for a few cycles, then returns.
   task automatic bounce(input logic [3:0] lo, input int len);
      logic [3:0] keep;
      keep = termLow;
      @(posedge sys_clk);
      termLow <= lo;
      repeat (len) @(posedge sys_clk);
      termLow <= keep;
   endtask : bounce

   // The alarm level changes on the clock edge, as the drive logic would.
   task automatic set_alarm(input logic v);
      @(posedge sys_clk);
      alarmLvl <= v;
   endtask : set_alarm
endmodule : terminal_source_model
`default_nettype wire

// [tb.sv]
// Self-checking bench for the digital input conditioning block.
// Assumes the block answers AXI4-Lite from registers and runs one control cycle a clock.
`timescale 1ns/1ns
`default_nettype none

module tb;
   logic sys_clk, rst_b; // Clock and active-low reset.
   digital_input_pkg::axi_req_t axiReq; // Master side of the register bus.
   digital_input_pkg::axi_rsp_t axiRsp; // Slave answers.
   logic [3:0] termLow, termHigh; // Terminal levels from the model.
   logic alarmLvl; // Raw alarm level.
   logic [7:0] condIn; // Conditioned inputs.
   logic alarmOut; // Filtered alarm.
   int err_count, checks; // Mismatch and comparison counters.
   logic [1:0] resp; // Last bus response.
   logic [31:0] rdVal; // Last read data.
   int n; // Measured delay in cycles.

   digital_input_conditioning #(.CTRL_DIV(1)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .axiReq(axiReq),
      .axiRsp(axiRsp), .inputTerminalA(termLow[0]), .inputTerminalB(termLow[1]), .inputTerminalC(termLow[2]),
      .inputTerminalD(termLow[3]), .inputTerminalHigh(termHigh), .alarmIn(alarmLvl), .condIn(condIn),
      .alarmOut(alarmOut));
   terminal_source_model src_u (.sys_clk(sys_clk), .termLow(termLow), .termHigh(termHigh), .alarmLvl(alarmLvl));

   // ==========================================================================
   // Clock, watchdog and verdict
   // ==========================================================================
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // The whole run needs well under 2000 cycles; ten times that means a hang.
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      tally_and_finish();
   end

   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // ==========================================================================
   // AXI4-Lite master: each valid held until its own ready is sampled high, bready and rready until their valid.
   // ==========================================================================
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      axiReq.awvalid <= 1'b1;
      axiReq.awaddr <= a;
      axiReq.wvalid <= 1'b1;
      axiReq.wdata <= d;
      axiReq.wstrb <= 4'hF;
      axiReq.bready <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
         if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
         if (axiReq.bready && axiRsp.bvalid) begin
            resp = axiRsp.bresp;
            axiReq.bready <= 1'b0;
            break;
         end
      end
      // One idle edge, so a following call never raises bready in the step that lowered it.
      @(posedge sys_clk);
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a);
      axiReq.arvalid <= 1'b1;
      axiReq.araddr <= a;
      axiReq.rready <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
         if (axiReq.rready && axiRsp.rvalid) begin
            rdVal = axiRsp.rdata;
            resp = axiRsp.rresp;
            axiReq.rready <= 1'b0;
            break;
         end
      end
      // One idle edge, so a following call never raises rready in the step that lowered it.
      @(posedge sys_clk);
   endtask : axi_read

   // Counts cycles until the chosen output leaves its present level (64 at most).
   task automatic measure(input bit alarm);
      logic start;
      start = alarm ? alarmOut : condIn[0];
      n = 0;
      while ((alarm ? alarmOut : condIn[0]) === start && n < 64) begin
         @(posedge sys_clk);
         n++;
         #1;
      end
      // Realigns to a rising edge so the next stimulus is launched on the clock.
      @(posedge sys_clk);
   endtask : measure

   // ==========================================================================
   // Scenarios
   // ==========================================================================
   // Reset values of every setting, then an unmapped read and a status write.
   task automatic t_reset();
      logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
      logic [31:0] exps [7] = '{32'h0, 32'h0, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0};
      for (int i = 0; i < 7; i++) begin
         axi_read(offs[i]);
         chk(rdVal, exps[i]);
      end
      axi_read(8'h1C);
      chk(rdVal, 32'h0000_0000);
      chk({30'h0, resp}, {30'h0, digital_input_pkg::RESP_SLVERR});
      axi_write(digital_input_pkg::OFF_STATUS, 32'h0000_00FF);
      chk({30'h0, resp}, {30'h0, digital_input_pkg::RESP_SLVERR});
      $display("test reset done");
   endtask : t_reset

   // Source select per group and inversion of the low group, filter off.
   task automatic t_select();
      axi_write(digital_input_pkg::OFF_FILTER, 32'h0);
      axi_write(digital_input_pkg::OFF_BUS_VALUE, 32'hA5);
      axi_write(digital_input_pkg::OFF_INVERT, 32'h3);
      axi_write(digital_input_pkg::OFF_SEL_LOW, 32'hF);
      axi_write(digital_input_pkg::OFF_SEL_HIGH, 32'hF);
      repeat (8) @(posedge sys_clk);
      chk(32'(condIn), 32'h0000_00A6);
      axi_read(digital_input_pkg::OFF_STATUS);
      chk(rdVal, 32'h0000_00A6);
      // Bus-sourced low inputs without inversion must follow the bus value as written.
      axi_write(digital_input_pkg::OFF_INVERT, 32'h0);
      repeat (8) @(posedge sys_clk);
      chk(32'(condIn), 32'h0000_00A5);
      axi_write(digital_input_pkg::OFF_INVERT, 32'h3);
      axi_write(digital_input_pkg::OFF_SEL_HIGH, 32'h0);
      repeat (8) @(posedge sys_clk);
      chk(32'(condIn), 32'h0000_0006);
      axi_write(digital_input_pkg::OFF_SEL_LOW, 32'h0);
      repeat (8) @(posedge sys_clk);
      chk(32'(condIn), 32'h0000_0003);
      axi_write(digital_input_pkg::OFF_INVERT, 32'h0);
      $display("test select done");
   endtask : t_select

   // Filter length, clamp above 1000, rejection of a short bounce, zero setting.
   task automatic t_filter();
      axi_write(digital_input_pkg::OFF_FILTER, 32'h0000_07D0);
      axi_read(digital_input_pkg::OFF_FILTER);
      chk(rdVal, 32'h0000_03E8);
      axi_write(digital_input_pkg::OFF_FILTER, 32'h0000_000A);
      repeat (8) @(posedge sys_clk);
      src_u.drive(4'h1, 4'h0);
      measure(1'b0);
      chk(32'(n >= 11 && n <= 17), 32'h1);
      src_u.bounce(4'h0, 4);
      repeat (30) @(posedge sys_clk);
      chk(32'(condIn[0]), 32'h1);
      axi_write(digital_input_pkg::OFF_FILTER, 32'h0);
      // All low terminals and high terminals 0 and 3 move at once, so each low terminal path and two high paths are seen.
      src_u.drive(4'hE, 4'h9);
      measure(1'b0);
      chk(32'(n <= 6), 32'h1);
      chk(32'(condIn), 32'h0000_009E);
      $display("test filter done");
   endtask : t_filter

   // Alarm filter at its longest setting and at zero.
   task automatic t_alarm();
      axi_write(digital_input_pkg::OFF_ALARM, 32'h3);
      src_u.set_alarm(1'b1);
      measure(1'b1);
      chk(32'(n >= 6 && n <= 9), 32'h1);
      // The filtered alarm level must also show in the status word.
      axi_read(digital_input_pkg::OFF_STATUS);
      chk(rdVal, 32'h0000_019E);
      axi_write(digital_input_pkg::OFF_ALARM, 32'h0);
      src_u.set_alarm(1'b0);
      measure(1'b1);
      chk(32'(n <= 2), 32'h1);
      $display("test alarm done");
   endtask : t_alarm

   // Main sequence: reset for 16 cycles, then the scenarios in turn.
   initial begin
      axiReq = '0;
      rst_b = 1'b0;
      err_count = 0;
      checks = 0;
      repeat (16) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge sys_clk);
      t_reset();
      t_select();
      t_filter();
      t_alarm();
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
